// File: hdl/ata_read_pkg.sv
// Purpose: constants and carrier types for the read command engine
// Assumes: task-file registers at offsets 1..7
// Notes:   data port is 16 bits wide; byte transfers sit in bits 7:0
// Functional notes
// - E4 returns the sector buffer with the normal read handshake.
// - Start address: head 27-24, high 23-16, mid 15-8, low 7-0.
// - DMA words move only under DMA request.
// - DMA read interrupts once, at the end, with final status.
// - Busy or data request set through the DMA phase.
// - Multiple read C4 interrupts once per block, not per sector.
// - Block size at most one sector, reported in identify data.
// - Data request gates a multiple read only at each block start.
// - Multiple read count is sectors: full blocks, then a partial block.
// - Multiple read without a valid block size is aborted.
// - Media error in multiple read is posted at block start, block still sent.
// - Multiple read interrupts at each block-start data request.
// - Read 1 to 256 sectors; a count of zero means 256.
// - Start at task-file address; finish holding the last sector address.
// - On read error stop there, keep its address and buffered data.
// - Multiple read continues past an error only if it was corrected.
// - Long read 22/23 returns 516 bytes without checking check bytes.
// - Long read is one sector: 256 words then 4 byte transfers.
// - F8 reports the factory native maximum address.
// - That native maximum bounds any later set-max request.
// - Native maximum is split over head, high, mid and low bytes.
// - Per PIO sector: busy, fill buffer, data request, clear busy, interrupt.
package ata_read_pkg;
    localparam logic [2:0] REG_FEATURE  = 3'h1;
    localparam logic [2:0] REG_COUNT    = 3'h2;
    localparam logic [2:0] REG_ADDR_LO  = 3'h3;
    localparam logic [2:0] REG_ADDR_MID = 3'h4;
    localparam logic [2:0] REG_ADDR_HI  = 3'h5;
    localparam logic [2:0] REG_DRVHEAD  = 3'h6;
    localparam logic [2:0] REG_COMMAND  = 3'h7;

    localparam logic [7:0] CMD_READ_BUFFER = 8'hE4;
    localparam logic [7:0] CMD_READ_DMA    = 8'hC8;
    localparam logic [7:0] CMD_READ_MULTI  = 8'hC4;
    localparam logic [7:0] CMD_READ_LONG   = 8'h22;
    localparam logic [7:0] CMD_READ_LONG_R = 8'h23;
    localparam logic [7:0] CMD_NATIVE_MAX  = 8'hF8;

    localparam int         WORDS_PER_SECTOR = 256;
    localparam int         CHECK_BYTES      = 4;
    localparam logic [8:0] COUNT_ZERO_MEANS = 9'h100;
    localparam logic [8:0] MAX_BLOCK_SIZE   = 9'h001;

    // error register bits
    localparam int ERR_ABORT_BIT = 2;
    localparam int ERR_UNC_BIT   = 6;
    // status register bits
    localparam int ST_ERR  = 0;
    localparam int ST_CORR = 2;
    localparam int ST_DRQ  = 3;
    localparam int ST_RDY  = 6;
    localparam int ST_BSY  = 7;

    // media fetch request
    typedef struct packed {
        logic        valid;
        logic [27:0] lba;
        logic        raw;
    } media_req_t;

    // media completion report
    typedef struct packed {
        logic done;
        logic corrected;
        logic uncorrectable;
    } media_rsp_t;
endpackage

// File: hdl/sector_counter.sv
// Purpose: beat counter for one transfer phase
// Assumes: step counts one beat per cycle it is high and may be held high; load may be held high between phases
// Notes:   last flags the final beat of the phase
`timescale 1ns/1ps
module sector_counter #(
    parameter int WIDTH = 9
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] limit,
    input  wire logic             step,
    output logic                  last
);
    logic [WIDTH-1:0] count_reg;

    // counts beats from zero until load clears it; limit only sets last
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else if (load) begin
            count_reg <= '0;
        end else if (step) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    assign last = (count_reg == limit - 1'b1);
endmodule

// File: hdl/ata_read_command_engine.sv
// Purpose: execution of the read family of task-file commands
// Assumes: all inputs synchronous to mclk
// Notes:   sector buffer lives here; media fills it word by word
`timescale 1ns/1ps
module ata_read_command_engine #(
    parameter logic [27:0] NATIVE_MAX_LBA = 28'h00F_FFFF,
    parameter int          BUF_WORDS      = 256
) (
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    // host task-file port
    input  wire logic [2:0]               reg_addr,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    input  wire logic [7:0]               reg_wdata,
    output logic [7:0]                    reg_rdata,
    // host data port, PIO or DMA
    input  wire logic                     data_rd,
    output logic [15:0]                   data_out,
    output logic                          data_byte_mode,
    output logic                          dmarq,
    input  wire logic                     dmack_n,
    output logic                          intrq,
    // block size from the set-multiple handler
    input  wire logic                     multi_valid,
    input  wire logic [8:0]               multi_size,
    output logic [8:0]                    identify_max_block,
    output logic [27:0]                   set_max_bound,
    // media side
    output ata_read_pkg::media_req_t      media_req,
    input  wire ata_read_pkg::media_rsp_t media_rsp,
    input  wire logic                     media_wr,
    input  wire logic [15:0]              media_wdata,
    input  wire logic [7:0]               media_check,
    input  wire logic                     media_check_wr
);
    typedef enum {S_IDLE, S_FETCH, S_XFER, S_CHECK, S_DONE} state_t;
    typedef enum {K_NONE, K_BUF, K_DMA, K_MULTI, K_LONG} kind_t;

    state_t       state_reg;
    kind_t        kind_reg;
    logic [7:0]   feature_reg;
    logic [7:0]   count_reg;
    logic [7:0]   lo_reg;
    logic [7:0]   mid_reg;
    logic [7:0]   hi_reg;
    logic [7:0]   dh_reg;
    logic [7:0]   status_reg;
    logic [7:0]   error_reg;
    logic [8:0]   remain_reg;
    logic [8:0]   blk_left_reg;
    logic         stop_reg;
    logic         intrq_reg;
    logic         first_reg;
    logic [15:0]  buf_mem [BUF_WORDS];
    logic [7:0]   check_mem [ata_read_pkg::CHECK_BYTES];
    logic [7:0]   mwidx_reg;
    logic [15:0]  data_reg;
    logic         byte_reg;

    // address and command decode
    wire          wr_cmd    = reg_wr && (reg_addr == ata_read_pkg::REG_COMMAND);
    wire          rd_status = reg_rd && (reg_addr == ata_read_pkg::REG_COMMAND);
    wire          idle      = (state_reg == S_IDLE);
    wire  [7:0]   cmd       = reg_wdata;
    wire  [27:0]  cur_lba   = {dh_reg[3:0], hi_reg, mid_reg, lo_reg};
    wire  [27:0]  nxt_lba   = cur_lba + 28'h1;
    wire  [8:0]   req_count = (count_reg == 8'h00) ? ata_read_pkg::COUNT_ZERO_MEANS
                                                   : {1'b0, count_reg};
    wire          multi_ok  = multi_valid && (multi_size != 9'h000)
                              && (multi_size <= ata_read_pkg::MAX_BLOCK_SIZE);
    wire          is_long   = (cmd == ata_read_pkg::CMD_READ_LONG)
                              || (cmd == ata_read_pkg::CMD_READ_LONG_R);
    wire          in_xfer   = (state_reg == S_XFER);
    wire          in_check  = (state_reg == S_CHECK);
    wire          is_dma    = (kind_reg == K_DMA);

    // dma beats need request and acknowledge
    wire          beat      = (in_xfer || in_check)
                              && (is_dma ? (dmarq && !dmack_n && data_rd) : data_rd);
    wire          word_last;
    wire          chk_last;
    wire  [8:0]   blk_size  = (remain_reg < multi_size) ? remain_reg : multi_size;
    wire  [7:0]   word_idx;
    wire          media_bad = media_rsp.uncorrectable;

    assign identify_max_block = ata_read_pkg::MAX_BLOCK_SIZE;
    assign set_max_bound      = NATIVE_MAX_LBA;

    sector_counter #(.WIDTH(9)) u_words (
        .mclk  (mclk),
        .rst_n (rst_n),
        .load  (state_reg != S_XFER),
        .limit (9'(ata_read_pkg::WORDS_PER_SECTOR)),
        .step  (in_xfer && beat),
        .last  (word_last)
    );

    sector_counter #(.WIDTH(3)) u_check (
        .mclk  (mclk),
        .rst_n (rst_n),
        .load  (!in_check),
        .limit (3'(ata_read_pkg::CHECK_BYTES)),
        .step  (in_check && beat),
        .last  (chk_last)
    );

    // host read index into the buffer and check bytes
    logic [7:0]   ridx_reg;

    assign word_idx = ridx_reg;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ridx_reg <= 8'h00;
        end else if (!in_xfer && !in_check) begin
            ridx_reg <= 8'h00;
        end else if (beat) begin
            ridx_reg <= ridx_reg + 8'h01;
        end
    end

    // media writes fill the sector buffer
    always_ff @(posedge mclk) begin
        if (media_wr) begin
            buf_mem[mwidx_reg] <= media_wdata;
        end
        if (media_check_wr) begin
            check_mem[mwidx_reg[1:0]] <= media_check;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mwidx_reg <= 8'h00;
        end else if (state_reg != S_FETCH) begin
            mwidx_reg <= 8'h00;
        end else if (media_wr || media_check_wr) begin
            mwidx_reg <= mwidx_reg + 8'h01;
        end
    end


    // output beat: words, then check bytes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            data_reg <= 16'h0000;
            byte_reg <= 1'b0;
        end else if (in_xfer) begin
            data_reg <= buf_mem[word_idx + (beat ? 8'h01 : 8'h00)];
            byte_reg <= 1'b0;
        end else if (in_check) begin
            data_reg <= {8'h00, check_mem[beat ? 2'(ridx_reg + 8'h01) : ridx_reg[1:0]]};
            byte_reg <= 1'b1;
        end else begin
            data_reg <= buf_mem[8'h00];
            byte_reg <= 1'b0;
        end
    end

    assign data_out       = data_reg;
    assign data_byte_mode = byte_reg;


    // task file: host writes when idle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            feature_reg <= 8'h00;
            count_reg   <= 8'h01;
            lo_reg      <= 8'h01;
            mid_reg     <= 8'h00;
            hi_reg      <= 8'h00;
            dh_reg      <= 8'hA0;
        end else if (idle && reg_wr) begin
            case (reg_addr)
                ata_read_pkg::REG_FEATURE:  feature_reg <= reg_wdata;
                ata_read_pkg::REG_COUNT:    count_reg   <= reg_wdata;
                ata_read_pkg::REG_ADDR_LO:  lo_reg      <= reg_wdata;
                ata_read_pkg::REG_ADDR_MID: mid_reg     <= reg_wdata;
                ata_read_pkg::REG_ADDR_HI:  hi_reg      <= reg_wdata;
                ata_read_pkg::REG_DRVHEAD:  dh_reg      <= reg_wdata;
                default: ;
            endcase
            if (wr_cmd && cmd == ata_read_pkg::CMD_NATIVE_MAX) begin
                {dh_reg[3:0], hi_reg, mid_reg, lo_reg} <= NATIVE_MAX_LBA;
            end
        end else if (in_xfer && word_last && beat && !stop_reg && remain_reg > 9'h001
                     && kind_reg != K_BUF && kind_reg != K_LONG) begin
            // advance only when another sector follows, so the last read stays
            {dh_reg[3:0], hi_reg, mid_reg, lo_reg} <= nxt_lba;
        end
    end

    // command sequencer
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg    <= S_IDLE;
            kind_reg     <= K_NONE;
            status_reg   <= 8'h40;
            error_reg    <= 8'h00;
            remain_reg   <= 9'h000;
            blk_left_reg <= 9'h000;
            stop_reg     <= 1'b0;
            intrq_reg    <= 1'b0;
            first_reg    <= 1'b0;
            media_req    <= '0;
        end else begin
            media_req.valid <= 1'b0;
            if (rd_status) begin
                intrq_reg <= 1'b0;
            end
            case (state_reg)
                S_IDLE: begin
                    if (wr_cmd) begin
                        error_reg  <= 8'h00;
                        stop_reg   <= 1'b0;
                        first_reg  <= 1'b1;
                        status_reg <= 8'h80;
                        intrq_reg  <= 1'b0;
                        state_reg  <= S_FETCH;
                        remain_reg <= req_count;
                        media_req  <= '{valid: 1'b1, lba: cur_lba, raw: is_long};
                        case (cmd)
                            ata_read_pkg::CMD_READ_BUFFER: begin
                                kind_reg   <= K_BUF;
                                remain_reg <= 9'h001;
                                media_req  <= '0;
                                state_reg  <= S_XFER;
                                status_reg <= 8'h48;
                                intrq_reg  <= 1'b1;
                            end

                            ata_read_pkg::CMD_READ_DMA: kind_reg <= K_DMA;
                            ata_read_pkg::CMD_READ_MULTI: begin
                                kind_reg     <= K_MULTI;
                                blk_left_reg <= 9'h000;
                                if (!multi_ok) begin
                                    error_reg[ata_read_pkg::ERR_ABORT_BIT] <= 1'b1;
                                    media_req  <= '0;
                                    state_reg  <= S_DONE;
                                end
                            end
                            ata_read_pkg::CMD_READ_LONG,
                            ata_read_pkg::CMD_READ_LONG_R: begin
                                kind_reg   <= K_LONG;
                                remain_reg <= 9'h001;
                            end
                            ata_read_pkg::CMD_NATIVE_MAX: begin
                                kind_reg  <= K_NONE;
                                media_req <= '0;
                                state_reg <= S_DONE;
                            end
                            default: begin
                                kind_reg  <= K_NONE;
                                media_req <= '0;
                                state_reg <= S_IDLE;
                                status_reg <= 8'h40;
                            end
                        endcase
                    end
                end

                S_FETCH: begin
                    if (media_rsp.done) begin
                        // raw long reads skip checking
                        if (kind_reg != K_LONG && media_bad) begin
                            error_reg[ata_read_pkg::ERR_UNC_BIT] <= 1'b1;
                            stop_reg <= (kind_reg != K_MULTI) || (blk_left_reg <= 9'h001)
                                        || (remain_reg == 9'h001);
                        end
                        state_reg <= S_XFER;
                        status_reg[ata_read_pkg::ST_BSY] <= 1'b0;
                        status_reg[ata_read_pkg::ST_DRQ] <= 1'b1;
                        status_reg[ata_read_pkg::ST_RDY] <= 1'b1;
                        status_reg[ata_read_pkg::ST_ERR] <= (kind_reg != K_LONG) && media_bad;
                        status_reg[ata_read_pkg::ST_CORR] <= media_rsp.corrected;
                        if (kind_reg == K_MULTI) begin
                            if (blk_left_reg <= 9'h001) begin
                                // a new block starts: error posted, data request, interrupt
                                blk_left_reg <= blk_size;
                                intrq_reg    <= 1'b1;
                            end else begin
                                blk_left_reg <= blk_left_reg - 9'h001;
                            end
                        end else if (kind_reg != K_DMA) begin
                            intrq_reg <= 1'b1;
                        end
                    end
                end

                S_XFER: begin
                    if (beat && word_last) begin
                        first_reg <= 1'b0;
                        if (kind_reg == K_LONG) begin
                            state_reg <= S_CHECK;
                        end else if (remain_reg <= 9'h001 || (stop_reg
                                     && (kind_reg != K_MULTI || blk_left_reg <= 9'h001))) begin
                            state_reg <= S_DONE;
                        end else begin
                            // multi keeps going in a block after an uncorrectable error at its start
                            remain_reg <= remain_reg - 9'h001;
                            state_reg  <= S_FETCH;
                            status_reg <= 8'h80;
                            media_req  <= '{valid: 1'b1, lba: nxt_lba, raw: 1'b0};
                        end
                    end
                end

                S_CHECK: begin
                    if (beat && chk_last) begin
                        state_reg <= S_DONE;
                    end
                end

                S_DONE: begin
                    state_reg  <= S_IDLE;
                    status_reg <= 8'h40;
                    status_reg[ata_read_pkg::ST_ERR] <= |error_reg;
                    // PIO reads already interrupted per sector or block
                    if (kind_reg == K_DMA || kind_reg == K_NONE || error_reg != 8'h00) begin
                        intrq_reg <= 1'b1;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    assign dmarq = is_dma && in_xfer;
    assign intrq = intrq_reg;

    // register read mux
    always_comb begin
        case (reg_addr)
            ata_read_pkg::REG_FEATURE:  reg_rdata = error_reg;
            ata_read_pkg::REG_COUNT:    reg_rdata = count_reg;
            ata_read_pkg::REG_ADDR_LO:  reg_rdata = lo_reg;
            ata_read_pkg::REG_ADDR_MID: reg_rdata = mid_reg;
            ata_read_pkg::REG_ADDR_HI:  reg_rdata = hi_reg;
            ata_read_pkg::REG_DRVHEAD:  reg_rdata = dh_reg;
            ata_read_pkg::REG_COMMAND:  reg_rdata = status_reg;
            default:                    reg_rdata = 8'h00;
        endcase
    end
endmodule

// File: tb/ata_read_monitor.sv
// Purpose: port checks for the read engine
// Assumes: one mclk domain, rst_n async active low
// Notes:   bound into every engine instance
`timescale 1ns/1ps
module ata_read_monitor #(
    parameter logic [27:0] NATIVE_MAX_LBA = 28'h00F_FFFF
) (
    input wire logic                     mclk,
    input wire logic                     rst_n,
    input wire logic [2:0]               reg_addr,
    input wire logic                     reg_wr,
    input wire logic [7:0]               reg_wdata,
    input wire logic [7:0]               reg_rdata,
    input wire logic                     data_rd,
    input wire logic                     dmarq,
    input wire logic                     dmack_n,
    input wire logic                     intrq,
    input wire logic                     multi_valid,
    input wire logic [8:0]               identify_max_block,
    input wire logic [27:0]              set_max_bound,
    input wire ata_read_pkg::media_req_t media_req
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // command write while not busy
    sequence cmd_idle(logic [7:0] c);
        reg_wr && reg_addr == 3'h7 && reg_wdata == c && (reg_rdata & 8'h88) == 8'h00;
    endsequence
    // fetch request with raw flag
    sequence fetch_raw(logic r);
        media_req.valid && media_req.raw == r;
    endsequence
    ident_one_a: assert property (identify_max_block == 9'h001)
        else $error("block limit not one");
    bound_max_a: assert property (set_max_bound == NATIVE_MAX_LBA)
        else $error("bad set-max bound");
    dma_fetch_a: assert property (cmd_idle(8'hC8) |=> fetch_raw(1'b0))
        else $error("dma fetch missing");
    long_raw_a: assert property (cmd_idle(8'h22) |=> fetch_raw(1'b1))
        else $error("long read fetch not raw");
    abort_quiet_a: assert property (cmd_idle(8'hC4) ##0 !multi_valid
        |=> !media_req.valid [*4]) else $error("aborted read fetched");
    dma_qual_a: assert property (data_rd && !dmack_n |-> dmarq)
        else $error("dma beat without request");
    dma_noirq_a: assert property (dmarq |-> !$rose(intrq))
        else $error("interrupt in dma phase");
    dma_status_a: assert property (dmarq && reg_addr == 3'h7 |-> |(reg_rdata & 8'h88))
        else $error("dma status idle");
endmodule
bind ata_read_command_engine ata_read_monitor #(.NATIVE_MAX_LBA(NATIVE_MAX_LBA)) mon (
    .mclk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .data_rd, .dmarq,
    .dmack_n, .intrq, .multi_valid, .identify_max_block, .set_max_bound, .media_req);

// File: tb/flash_media_model.sv
// Purpose: flash media stand-in answering sector fetches
// Assumes: fetch requests are one-cycle pulses; drives at falling edges
// Notes:   word i of block L is {L[7:0], i}; check byte i is C0h+i
`timescale 1ns/1ps
module flash_media_model (
    input  wire logic                     mclk,
    input  wire ata_read_pkg::media_req_t media_req,
    input  wire logic                     slow,
    input  wire logic                     fail_unc,
    output ata_read_pkg::media_rsp_t      media_rsp,
    output logic                          media_wr,
    output logic [15:0]                   media_wdata,
    output logic [7:0]                    media_check,
    output logic                          media_check_wr
);
    // words, then check bytes, then a done pulse
    initial begin
        {media_rsp, media_wr, media_check_wr} = '0;
        {media_wdata, media_check} = 24'hFFFFFF;
        forever begin
            @(negedge mclk);
            if (media_req.valid) begin
                repeat (slow ? 40 : 2) @(negedge mclk);
                for (int i = 0; i < 260; i++) begin
                    media_wr = (i < 256);
                    media_check_wr = (i >= 256);
                    media_check = 8'hC0 + 8'(i - 256);
                    media_wdata = {media_req.lba[7:0], 8'(i)};
                    @(negedge mclk);
                end
                {media_wr, media_check_wr} = 2'b00;
                media_wdata = ~media_wdata; // idle bus shows inverse
                media_rsp = {1'b1, 1'b0, fail_unc};
                @(negedge mclk);
                media_rsp = '0;
            end
        end
    end
endmodule

// File: tb/ata_read_command_engine_test.sv
// Purpose: self-checking bench for the read engine
// Assumes: host drives at falling edges
// Notes:   native maximum is a distinct pattern to catch byte swaps
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module ata_read_command_engine_test;
    localparam logic [27:0] NMAX = 28'hA5B_C3D1;
    logic mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, data_rd = 1'b0;
    logic dmack_n = 1'b1, multi_valid = 1'b0, slow = 1'b0, fail_unc = 1'b0;
    logic [2:0]  reg_addr = 3'h0;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata, media_check, s;
    logic [15:0] data_out, media_wdata;
    logic [8:0]  multi_size = 9'h001, identify_max_block;
    logic [27:0] set_max_bound;
    logic        data_byte_mode, dmarq, intrq, media_wr, media_check_wr;
    ata_read_pkg::media_req_t media_req;
    ata_read_pkg::media_rsp_t media_rsp;
    int          bad_count = 0, samples_checked = 0;
    always #12.5 mclk = ~mclk;
    ata_read_command_engine #(.NATIVE_MAX_LBA(NMAX)) dut (.mclk, .rst_n, .reg_addr,
        .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .data_rd, .data_out, .data_byte_mode,
        .dmarq, .dmack_n, .intrq, .multi_valid, .multi_size, .identify_max_block,
        .set_max_bound, .media_req, .media_rsp, .media_wr, .media_wdata, .media_check,
        .media_check_wr);
    flash_media_model media (.mclk, .media_req, .slow, .fail_unc, .media_rsp, .media_wr,
        .media_wdata, .media_check, .media_check_wr);
    task finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // one register cycle; read data lands in s
    task acc(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(negedge mclk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, ~w, a, d};
        #1 s = reg_rdata;
        @(negedge mclk);
        {reg_wr, reg_rd} = 2'b00;
    endtask
    // bounded wait for intrq or dmarq
    task wait_hi(input logic dma);
        int n;
        for (n = 0; n < 3000 && (dma ? dmarq : intrq) !== 1'b1; n++)
            @(negedge mclk);
        if (n == 3000) begin
            bad_count++;
            finish_test();
        end
    endtask
    // bounded status poll until idle
    task wait_idle();
        for (int n = 0; n < 3000; n++) begin
            acc(1'b0, 3'h7, 8'h00);
            if ((s & 8'h88) === 8'h00) return;
        end
        bad_count++;
        finish_test();
    endtask
    // take one sector, expecting {hi, index}
    task take(input logic [7:0] hi, input logic dma);
        for (int i = 0; i < 256; i++) begin
            @(negedge mclk);
            {dmack_n, data_rd} = {~dma, 1'b1};
            `CHK("data word", {hi, 8'(i)}, data_out)
        end
        @(negedge mclk);
        {dmack_n, data_rd} = 2'b10;
    endtask
    task setup(input logic [27:0] lba, input logic [7:0] cnt);
        acc(1'b1, 3'h6, {4'hE, lba[27:24]});
        acc(1'b1, 3'h5, lba[23:16]);
        acc(1'b1, 3'h4, lba[15:8]);
        acc(1'b1, 3'h3, lba[7:0]);
        acc(1'b1, 3'h2, cnt);
    endtask
    initial begin
        repeat (6) @(negedge mclk);
        rst_n = 1'b1;
        `CHK("block limit", 9'h001, identify_max_block)
        `CHK("set-max bound", NMAX, set_max_bound)
        // native maximum, byte by byte
        acc(1'b1, 3'h7, 8'hF8);
        wait_hi(1'b0);
        wait_idle();
        for (int k = 0; k < 4; k++) begin
            acc(1'b0, 3'h6 - 3'(k), 8'h00);
            `CHK("max byte", 8'(NMAX >> (8 * (3 - k))), k == 0 ? s & 8'h0F : s)
        end
        // block read refused without block size
        setup(28'h0123450, 8'h02);
        acc(1'b1, 3'h7, 8'hC4);
        wait_hi(1'b0);
        acc(1'b0, 3'h7, 8'h00);
        `CHK("abort status", 8'h41, s)
        acc(1'b0, 3'h1, 8'h00);
        `CHK("abort bit", 1'b1, s[2])
        // two blocks, first served slowly
        {multi_valid, slow} = 2'b11;
        setup(28'h0123456, 8'h02);
        acc(1'b1, 3'h7, 8'hC4);
        for (int b = 0; b < 2; b++) begin
            wait_hi(1'b0);
            acc(1'b0, 3'h7, 8'h00);
            `CHK("block status", 8'h48, s)
            take(8'h56 + 8'(b), 1'b0);
            slow = 1'b0;
        end
        wait_idle();
        acc(1'b0, 3'h3, 8'h00);
        `CHK("last address", 8'h57, s)
        // buffer still holds the last sector
        acc(1'b1, 3'h7, 8'hE4);
        wait_hi(1'b0);
        take(8'h57, 1'b0);
        wait_idle();
        // dma read, acknowledge driven only once dmarq is up
        setup(28'h0000020, 8'h01);
        acc(1'b1, 3'h7, 8'hC8);
        wait_hi(1'b1);
        `CHK("early intrq", 1'b0, intrq)
        acc(1'b0, 3'h7, 8'h00);
        `CHK("dma busy or drq", 1'b1, s[7] | s[3])
        take(8'h20, 1'b1);
        wait_hi(1'b0);
        acc(1'b0, 3'h7, 8'h00);
        `CHK("dma end status", 8'h40, s)
        // long read, both codes
        for (int c = 0; c < 2; c++) begin
            setup(28'h0000031 + 28'(c), 8'h01);
            acc(1'b1, 3'h7, 8'h22 + 8'(c));
            wait_hi(1'b0);
            take(8'h31 + 8'(c), 1'b0);
            for (int i = 0; i < 4; i++) begin
                @(negedge mclk);
                data_rd = 1'b1;
                `CHK("check", {1'b1, 8'hC0 + 8'(i)}, {data_byte_mode, data_out[7:0]})
            end
            @(negedge mclk);
            data_rd = 1'b0;
            wait_idle();
        end
        // uncorrectable error in block one of three
        fail_unc = 1'b1;
        setup(28'h0000040, 8'h03);
        acc(1'b1, 3'h7, 8'hC4);
        wait_hi(1'b0);
        acc(1'b0, 3'h7, 8'h00);
        `CHK("block error", 8'h49, s)
        take(8'h40, 1'b0);
        wait_hi(1'b0);
        acc(1'b0, 3'h7, 8'h00);
        `CHK("stop status", 8'h41, s)
        acc(1'b0, 3'h1, 8'h00);
        `CHK("unc bit", 1'b1, s[6])
        acc(1'b0, 3'h3, 8'h00);
        `CHK("failing address", 8'h40, s)
        finish_test();
    end
endmodule
